// ### design/csc_pkg.sv
// Constants and carriers for the clock synthesizer control block.
// Assumes a single 250 MHz system clock domain.
package csc_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  IRQ_ST_OFS = 8'h04;
	localparam logic [7:0]  IRQ_EN_OFS = 8'h08;
	localparam logic [7:0]  IRQ_CL_OFS = 8'h0c;
	localparam logic [15:0] CTRL_RST   = 16'h3f00;

	// Control register fields
	localparam int PRESC_BIT = 15;
	localparam int HALVE_BIT = 14;
	localparam int MOD_HI    = 13;
	localparam int MOD_LO    = 8;
	localparam int LOCK_BIT  = 3;

	// Interrupt status bits
	localparam int IRQ_GAIN = 0;
	localparam int IRQ_LOSS = 1;

	// ----------------------------------------
	// Divider and lock counts
	// ----------------------------------------
	localparam logic [2:0] PRE_TOP_SLOW = 3'h1;
	localparam logic [2:0] PRE_TOP_FAST = 3'h7;
	localparam logic [2:0] FIN_TOP      = 3'h7;
	localparam logic [2:0] LOCK_MATCHES = 3'h4;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} csc_req_t;

	typedef struct packed {
		logic       prescale;
		logic       halve_bypass;
		logic [5:0] modulus;
	} csc_cfg_t;
endpackage

// ### design/csc_top.sv
// Clock synthesizer control: register, feedback divider, lock detect,
// power-up reset hold, output clock stage and interrupt.
// Assumes oscillator and reference pins toggle well below sys_clk_i / 4.
//
// Contract
// [R1] Lock is declared only when divided feedback matches the reference rate.
// [R2] Any change on either comparator input drops lock and forces a relock.
// [R3] The lock flag bit of the control register shows the current lock state.
// [R4] At power-up the chip reset output stays asserted until lock.
// [R5] The prescale bit makes a three-bit prescaler divide four times more.
// [R6] The modulus field loads a modulo-64 down counter dividing by modulus plus one.
// [R7] A change of prescale or modulus drops lock and needs a relock delay.
// [R8] The halve bypass bit clear gives a system clock of a quarter oscillator rate.
// [R9] Setting halve bypass doubles the system clock without any relock.
// [R10] System clock is reference times 4(modulus+1) times 2^(2*prescale+bypass).
// [R11] The control register resets to 16'h3f00, a divide-by-64 count.
// [R12] The multiplier spans 4 at lowest settings to 2048 with all bits set.
// [R13] Software must not pick settings exceeding oscillator or clock limits.
// [R14] A low mode pin at reset disables the synthesizer and its control bits.
// [R15] The lock flag is read-only; the three control fields are read-write.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module csc_top
	import csc_pkg::*;
(
	input  wire logic            sys_clk_i,
	input  wire logic            rst_n_i,
	input  wire csc_pkg::csc_req_t req_i,
	output logic [15:0]          rdata_o,
	input  wire logic            reference_input_i,
	input  wire logic            synth_oscillator_i,
	input  wire logic            clock_mode_pin_i,
	output logic                 sys_clk_out_o,
	output logic                 chip_rst_n_o,
	output logic                 irq_o
);
	import csc_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [1:0] ref_s_q, osc_s_q, mode_s_q;
	logic       ref_p_q, osc_p_q;

	// Two flops per pin, then an edge history flop
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ref_s_q  <= 2'h0;
			osc_s_q  <= 2'h0;
			ref_p_q  <= 1'b0;
			osc_p_q  <= 1'b0;
		end else begin
			ref_s_q  <= {ref_s_q[0], reference_input_i};
			osc_s_q  <= {osc_s_q[0], synth_oscillator_i};
			ref_p_q  <= ref_s_q[1];
			osc_p_q  <= osc_s_q[1];
		end
	end

	// Mode pin tracked through reset, so its level is ready at release
	always_ff @(posedge sys_clk_i) begin
		mode_s_q <= {mode_s_q[0], clock_mode_pin_i}; // R14
	end

	logic ref_rise, osc_rise;
	assign ref_rise = ref_s_q[1] & ~ref_p_q;
	assign osc_rise = osc_s_q[1] & ~osc_p_q;

	// ----------------------------------------
	// Mode capture at reset release
	// ----------------------------------------
	logic mode_q, taken_q;

	// Mode level taken once, first cycles after release
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mode_q  <= 1'b0;
			taken_q <= 1'b0;
		end else if (!taken_q) begin
			mode_q  <= mode_s_q[1]; // R14
			taken_q <= 1'b1;
		end
	end

	logic synth_on;
	assign synth_on = taken_q & mode_q;

	// ----------------------------------------
	// Control register
	// ----------------------------------------
	csc_cfg_t cfg_q;
	csc_cfg_t cfg_wr;
	logic     wr_ctrl, cfg_chg;

	assign wr_ctrl = req_i.wr && (req_i.addr == CTRL_OFS);
	assign cfg_wr  = '{prescale:     req_i.wdata[PRESC_BIT],
	                   halve_bypass: req_i.wdata[HALVE_BIT],
	                   modulus:      req_i.wdata[MOD_HI:MOD_LO]};
	// Only prescale or modulus change the oscillator
	assign cfg_chg = wr_ctrl && synth_on &&
	                 ((cfg_wr.prescale != cfg_q.prescale) ||
	                  (cfg_wr.modulus != cfg_q.modulus)); // R7

	// Writable fields; lock bit of the write data dropped
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_q <= '{prescale:     CTRL_RST[PRESC_BIT],
			           halve_bypass: CTRL_RST[HALVE_BIT],
			           modulus:      CTRL_RST[MOD_HI:MOD_LO]}; // R11
		end else if (wr_ctrl) begin
			cfg_q <= cfg_wr; // R15
		end
	end

	// ----------------------------------------
	// Feedback divider
	// ----------------------------------------
	logic [2:0] pre_q, fin_q, pre_top;
	logic [5:0] mod_q;
	logic       pre_fire, mod_fire, fb_pulse;

	// Prescaler top: divide by 2, or by 8 when fast
	assign pre_top  = cfg_q.prescale ? PRE_TOP_FAST : PRE_TOP_SLOW; // R5
	assign pre_fire = osc_rise && (pre_q >= pre_top);
	assign mod_fire = pre_fire && (mod_q == 6'h00);
	assign fb_pulse = mod_fire && (fin_q == FIN_TOP);

	// Prescaler, modulus down counter, final divide by 8
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pre_q <= 3'h0;
			mod_q <= CTRL_RST[MOD_HI:MOD_LO];
			fin_q <= 3'h0;
		end else if (cfg_chg) begin
			pre_q <= 3'h0;
			mod_q <= cfg_wr.modulus;
			fin_q <= 3'h0;
		end else if (osc_rise) begin
			pre_q <= pre_fire ? 3'h0 : pre_q + 3'h1; // R5
			if (mod_fire) begin
				mod_q <= cfg_q.modulus; // R6
				fin_q <= fin_q + 3'h1; // R10
			end else if (pre_fire) begin
				mod_q <= mod_q - 6'h01; // R6
			end
		end
	end

	// ----------------------------------------
	// Lock detector
	// ----------------------------------------
	logic [1:0] fb_cnt_q;
	logic [2:0] good_q;
	logic       lock_q, match, overrun;

	assign match   = (fb_cnt_q == 2'h1);
	assign overrun = (fb_cnt_q == 2'h3);

	// Feedback pulses seen in the current reference period
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fb_cnt_q <= 2'h0;
		end else if (ref_rise || cfg_chg) begin
			fb_cnt_q <= {1'b0, fb_pulse};
		end else if (fb_pulse && !overrun) begin
			fb_cnt_q <= fb_cnt_q + 2'h1;
		end
	end

	// Consecutive matching periods; any mismatch restarts
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			good_q <= 3'h0;
			lock_q <= 1'b0;
		end else if (!synth_on || cfg_chg) begin
			good_q <= 3'h0; // R7
			lock_q <= 1'b0; // R14
		end else if (overrun || (ref_rise && !match)) begin
			good_q <= 3'h0; // R2
			lock_q <= 1'b0; // R2
		end else if (ref_rise) begin
			if (good_q + 3'h1 >= LOCK_MATCHES) begin
				lock_q <= 1'b1; // R1
			end else begin
				good_q <= good_q + 3'h1;
			end
		end
	end

	// ----------------------------------------
	// Output clock stage
	// ----------------------------------------
	logic half_q, clk_q;

	// Toggle per oscillator edge (bypass) or every second edge
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			half_q <= 1'b0;
			clk_q  <= 1'b0;
		end else if (!synth_on) begin
			half_q <= 1'b0;
			clk_q  <= ref_s_q[1]; // R14
		end else if (osc_rise) begin
			half_q <= ~half_q;
			if (cfg_q.halve_bypass || half_q) begin
				clk_q <= ~clk_q; // R8 R9 R10 R12
			end
		end
	end
	assign sys_clk_out_o = clk_q;

	// ----------------------------------------
	// Power-up reset hold
	// ----------------------------------------
	logic chip_rst_n_q;

	// Released once at first lock, or at once on external clock
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			chip_rst_n_q <= 1'b0;
		end else if (taken_q && (lock_q || !mode_q)) begin
			chip_rst_n_q <= 1'b1; // R4
		end
	end
	assign chip_rst_n_o = chip_rst_n_q;

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [1:0] st_q, en_q, ev;
	logic       lock_p_q, irq_q;

	assign ev = {lock_p_q & ~lock_q, ~lock_p_q & lock_q};

	// Sticky status, set wins over clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lock_p_q <= 1'b0;
			st_q     <= 2'h0;
			en_q     <= 2'h0;
			irq_q    <= 1'b0;
		end else begin
			lock_p_q <= lock_q;
			if (req_i.wr && (req_i.addr == IRQ_CL_OFS)) begin
				st_q <= (st_q & ~req_i.wdata[1:0]) | ev;
			end else begin
				st_q <= st_q | ev;
			end
			if (req_i.wr && (req_i.addr == IRQ_EN_OFS)) begin
				en_q <= req_i.wdata[1:0];
			end
			irq_q <= |(st_q & en_q);
		end
	end
	assign irq_o = irq_q;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [15:0] rdata_q;

	// Data one cycle after the read strobe, zero elsewhere
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 16'h0000;
		end else if (!req_i.rd) begin
			rdata_q <= 16'h0000;
		end else if (req_i.addr == CTRL_OFS) begin
			rdata_q <= {cfg_q.prescale, cfg_q.halve_bypass, cfg_q.modulus,
			            4'h0, lock_q, 3'h0}; // R3
		end else if (req_i.addr == IRQ_ST_OFS) begin
			rdata_q <= {14'h0000, st_q};
		end else if (req_i.addr == IRQ_EN_OFS) begin
			rdata_q <= {14'h0000, en_q};
		end else begin
			rdata_q <= 16'h0000;
		end
	end
	assign rdata_o = rdata_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	lock_needs_match_a: assert property ( // R1
		$rose(lock_q) |-> $past(ref_rise) && $past(fb_cnt_q) == 2'h1)
		else $error("lock rose without a matching period");

	mismatch_drops_a: assert property ( // R2
		synth_on && ref_rise && fb_cnt_q != 2'h1 && !cfg_chg |=> !lock_q)
		else $error("lock held over a mismatched period");

	flag_reads_lock_a: assert property ( // R3
		req_i.rd && req_i.addr == CTRL_OFS |=> rdata_o[LOCK_BIT] == $past(lock_q))
		else $error("lock flag read differs from lock state");

	reset_held_a: assert property ( // R4
		$rose(chip_rst_n_o) |-> $past(lock_q) || !mode_q)
		else $error("chip reset released before lock");

	prescale_top_a: assert property ( // R5
		osc_rise && !cfg_chg |-> pre_fire == (pre_q >= (cfg_q.prescale ? 3'h7 : 3'h1)))
		else $error("prescaler terminal count wrong");

	modulus_load_a: assert property ( // R6
		mod_fire && !cfg_chg |=> mod_q == $past(cfg_q.modulus))
		else $error("modulus counter did not reload");

	relock_delay_a: assert property ( // R7
		cfg_chg |=> !lock_q ##1 !lock_q[*3])
		else $error("lock reported without relock delay");

	quarter_rate_a: assert property ( // R8
		synth_on && osc_rise && !cfg_q.halve_bypass && !half_q |=> $stable(sys_clk_out_o))
		else $error("output toggled on skipped oscillator edge");

	bypass_keeps_lock_a: assert property ( // R9
		wr_ctrl && lock_q && cfg_wr.prescale == cfg_q.prescale
		&& cfg_wr.modulus == cfg_q.modulus && !ref_rise && !overrun |=> lock_q)
		else $error("bypass change dropped lock");

	external_no_lock_a: assert property ( // R14
		taken_q && !mode_q |=> !lock_q && sys_clk_out_o == $past(ref_s_q[1]))
		else $error("synth active in external clock mode");

	lock_gain_c: cover property ($rose(lock_q));
	lock_loss_c: cover property ($fell(lock_q) && !$past(cfg_chg));
	bypass_locked_c: cover property (wr_ctrl && lock_q && cfg_wr.halve_bypass != cfg_q.halve_bypass);
	irq_c: cover property ($rose(irq_o));
endmodule

// ### tb/csc_src_model.sv
// Reference and oscillator pin source for the clock synthesizer control.
// Assumes half periods in system clock cycles, three or more.
`timescale 1ns/1ps
module csc_src_model (
	input  wire logic        sys_clk_i,
	input  wire logic        run_i,
	input  wire logic [15:0] osc_half_i,
	input  wire logic [15:0] ref_half_i,
	output logic             reference_o,
	output logic             oscillator_o
);
	logic [15:0] osc_cnt_q = 16'h0;
	logic [15:0] ref_cnt_q = 16'h0;
	logic        osc_q     = 1'b0;
	logic        ref_q     = 1'b0;

	// Quiet pins at time zero
	assign reference_o  = ref_q;
	assign oscillator_o = osc_q;

	// Pin toggling, kept well under the allowed rates
	always @(posedge sys_clk_i) begin
		osc_cnt_q <= (osc_cnt_q >= osc_half_i - 16'h1) ? 16'h0 : osc_cnt_q + 16'h1;
		ref_cnt_q <= (ref_cnt_q >= ref_half_i - 16'h1) ? 16'h0 : ref_cnt_q + 16'h1;
		if (run_i && osc_cnt_q >= osc_half_i - 16'h1) begin
			osc_q <= ~osc_q;
		end
		if (run_i && ref_cnt_q >= ref_half_i - 16'h1) begin
			ref_q <= ~ref_q;
		end
	end
endmodule

// ### tb/clock_synth_control_bench.sv
// Self-checking bench for the clock synthesizer control block.
// Assumes the pin source model and the design package.
`timescale 1ns/1ps
module clock_synth_control_bench;
	import csc_pkg::*;
	localparam int OSC_HALF = 3;
	logic        sys_clk_i;
	logic        rst_n_i;
	logic        mode_pin;
	logic        run;
	logic        ref_pin;
	logic        osc_pin;
	logic        out_clk;
	logic        chip_rst_n;
	logic        irq;
	logic [15:0] rdata;
	logic [15:0] ref_half;
	logic [15:0] rd_v;
	csc_req_t    req;
	int          error_cnt;
	int          compares;

	csc_top DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .req_i(req), .rdata_o(rdata),
		.reference_input_i(ref_pin), .synth_oscillator_i(osc_pin), .clock_mode_pin_i(mode_pin),
		.sys_clk_out_o(out_clk), .chip_rst_n_o(chip_rst_n), .irq_o(irq));
	csc_src_model u_src (.sys_clk_i(sys_clk_i), .run_i(run), .osc_half_i(16'(OSC_HALF)),
		.ref_half_i(ref_half), .reference_o(ref_pin), .oscillator_o(osc_pin));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Reference half period for a locked setting
	function automatic logic [15:0] exp_half(input logic w, input logic [5:0] y);
		return 16'(16 * (y + 1) * (w ? 4 : 1) * OSC_HALF);
	endfunction

	task automatic stop_test();
		if (error_cnt == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk_i);
		req <= '{1'b1, 1'b0, a, d};
		@(posedge sys_clk_i);
		req <= '0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk_i);
		req <= '{1'b0, 1'b1, a, 16'h0};
		@(posedge sys_clk_i);
		req <= '0;
		#1;
		d = rdata;
	endtask

	// Poll the lock flag until it shows the wanted level
	task automatic wait_lock(input logic exp);
		int n;
		n = 0;
		bus_rd(CTRL_OFS, rd_v);
		while (rd_v[LOCK_BIT] !== exp) begin
			n++;
			if (n > 20000) begin
				error_cnt++;
				stop_test();
			end
			bus_rd(CTRL_OFS, rd_v);
		end
	endtask

	// Four output clock periods in system cycles
	task automatic out_period(input logic x);
		int n;
		int k;
		int t0;
		logic prev;
		n = 0;
		k = 0;
		t0 = 0;
		prev = 1'b1;
		repeat (400) begin
			@(posedge sys_clk_i);
			#1;
			if (out_clk && !prev) begin
				if (k == 0) t0 = n;
				if (k == 4) break;
				k++;
			end
			prev = out_clk;
			n++;
		end
		check("out period", 16'(n - t0), 16'(4 * 2 * OSC_HALF * (x ? 2 : 4)));
	endtask

	// ----------------------------------------
	// Stimulus
	// ----------------------------------------
	// Free running system clock
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// Main sequence
	initial begin
		logic [15:0] v;
		logic        w;
		logic [5:0]  y;
		error_cnt = 0;
		compares = 0;
		rst_n_i = 1'b0;
		req = '0;
		mode_pin = 1'b1;
		run = 1'b0;
		ref_half = exp_half(1'b0, 6'h0);
		void'($urandom(32'h98a9));
		repeat (12) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		bus_rd(CTRL_OFS, v);
		check("ctrl reset", v, CTRL_RST);
		bus_wr(CTRL_OFS, 16'h0008);
		bus_rd(CTRL_OFS, v);
		check("ctrl lock ro", v, 16'h0000);
		bus_rd(8'h10, v);
		check("unmapped", v, 16'h0000);
		bus_wr(IRQ_EN_OFS, 16'h0003);
		bus_rd(IRQ_EN_OFS, v);
		check("irq enable", v, 16'h0003);
		check("chip held", {15'h0, chip_rst_n}, 16'h0);
		run <= 1'b1;
		wait_lock(1'b1);
		check("chip free", {15'h0, chip_rst_n}, 16'h1);
		// Status then interrupt flop lag the lock by two cycles
		repeat (2) @(posedge sys_clk_i);
		#1;
		check("irq gain", {15'h0, irq}, 16'h1);
		bus_wr(IRQ_CL_OFS, 16'h0001);
		repeat (3) @(posedge sys_clk_i);
		check("irq clear", {15'h0, irq}, 16'h0);
		out_period(1'b0);
		bus_wr(CTRL_OFS, 16'h4000);
		bus_rd(CTRL_OFS, v);
		check("bypass keeps lock", v, 16'h4008);
		out_period(1'b1);
		// Reference at half rate must never lock
		ref_half <= exp_half(1'b0, 6'h1);
		wait_lock(1'b0);
		repeat (2000) @(posedge sys_clk_i);
		bus_rd(CTRL_OFS, v);
		check("no lock", v, 16'h4000);
		check("irq loss", {15'h0, irq}, 16'h1);
		bus_wr(IRQ_EN_OFS, 16'h0000);
		repeat (3) @(posedge sys_clk_i);
		check("irq masked", {15'h0, irq}, 16'h0);
		bus_rd(IRQ_ST_OFS, v);
		check("loss status", v & 16'h0002, 16'h0002);
		bus_wr(IRQ_CL_OFS, 16'h0003);
		// Random settings, each differing from the last
		for (int i = 0; i < 3; i++) begin
			w = 1'($urandom % 2);
			y = 6'(i + 2 * ($urandom % 2));
			bus_wr(CTRL_OFS, {w, 1'b0, y, 8'h08});
			bus_rd(CTRL_OFS, v);
			check("relock start", v, {w, 1'b0, y, 8'h00});
			ref_half <= exp_half(w, y);
			wait_lock(1'b1);
			out_period(1'b0);
		end
		// External clock mode: chip free at once, no lock
		rst_n_i <= 1'b0;
		mode_pin <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		check("ext chip free", {15'h0, chip_rst_n}, 16'h1);
		bus_wr(CTRL_OFS, 16'h0000);
		ref_half <= exp_half(1'b0, 6'h0);
		repeat (1500) @(posedge sys_clk_i);
		bus_rd(CTRL_OFS, v);
		check("ext no lock", v, 16'h0000);
		stop_test();
	end
endmodule
